// ==== common/ofd_pkg.sv ====
// ==========================================================
// Operand field decoder shared constants
// ==========================================================
package ofd_pkg;
  // Operand kinds presented on the decode request port
  typedef enum logic [3:0] {
    OFD_K_AWB, OFD_K_BIT, OFD_K_FILE, OFD_K_TEN_BIT_UNSIGNED_LITERAL,
    OFD_K_PROGRAM_ADDRESS_LITERAL, OFD_K_TEN_BIT_SIGNED_LITERAL, OFD_K_SLIT16, OFD_K_SLIT6,
    OFD_K_WDEF, OFD_K_SQR, OFD_K_MUL, OFD_K_XPF,
    OFD_K_YPF, OFD_K_ACC, OFD_K_DEFAULT_FILE_WORKING_REG, OFD_K_SIZE
  } ofd_kind_type;

  // Register byte offsets
  localparam logic [7:0] OFD_A_CTRL  = 8'h00;
  localparam logic [7:0] OFD_A_ISTAT = 8'h04;
  localparam logic [7:0] OFD_A_IMASK = 8'h08;
  localparam logic [7:0] OFD_A_CORE  = 8'h0C;
  localparam logic [7:0] OFD_A_DSP   = 8'h10;
  localparam logic [7:0] OFD_A_LAST  = 8'h14;

  // Interrupt status bits
  localparam int OFD_I_ILL  = 0;
  localparam int OFD_I_DONE = 1;
  localparam int OFD_I_SAT  = 2;
  localparam int OFD_I_W    = 3;

  // Core flag bits: carry, digit carry, negative, overflow, zero
  localparam int OFD_F_C  = 0;
  localparam int OFD_F_DC = 1;
  localparam int OFD_F_N  = 2;
  localparam int OFD_F_OV = 3;
  localparam int OFD_F_Z  = 4;
  // DSP flag bits: overflow A/B, clip A/B
  localparam int OFD_D_OA = 0;
  localparam int OFD_D_OB = 1;
  localparam int OFD_D_SA = 2;
  localparam int OFD_D_SB = 3;

  // Working register numbers used by fixed fields
  localparam logic [3:0] OFD_W0  = 4'h0;
  localparam logic [3:0] OFD_W4  = 4'h4;
  localparam logic [3:0] OFD_W5  = 4'h5;
  localparam logic [3:0] OFD_W6  = 4'h6;
  localparam logic [3:0] OFD_W7  = 4'h7;
  localparam logic [3:0] OFD_W8  = 4'h8;
  localparam logic [3:0] OFD_W10 = 4'hA;
  localparam logic [3:0] OFD_W13 = 4'hD;
  localparam logic signed [3:0] OFD_AWB_STEP = 4'sh2;

  // Field limits
  localparam int         OFD_FILE_W   = 13;
  localparam logic [9:0] OFD_BYTE_MAX = 10'h0FF;
  localparam logic [3:0] OFD_PF_OFS   = 4'hE;
  localparam logic [3:0] OFD_PF_NONE  = 4'hF;
  localparam logic [3:0] OFD_PF_SPLIT = 4'h7;
endpackage

// ==== rtl/ofd_operand_decoder.sv ====
// Notes on behaviour
// [RL1] Write-back: W13 direct or [W13] plus two
// [RL2] Bit field: four bits, positions 0..15
// [RL3] File address: 0 up to 0x1FFF
// [RL4] Ten-bit literal: byte mode max 255
// [RL5] Program address literal must be even
// [RL6] Signed literals sign-extended, two's complement
// [RL7] Default file operand maps to W0
// [RL8] Square pairs: same register, W4..W7
// [RL9] Multiply pairs: six distinct W4..W7 combinations
// [RL10] X prefetch: W8/W9, modifiers, W9+W12, none
// [RL11] Y prefetch: W10/W11, modifiers, W11+W12, none
// [RL12] Prefetch destination is one of W4..W7
// [RL13] Core flags C DC N OV, sticky Z
// [RL14] DSP overflow and clip flags per accumulator
// [RL15] One bit selects accumulator A or B
// [RL16] Register fields select W0..W15
// [RL17] Size: byte, double, word default, shadow
// [RL18] Out-of-range encodings flagged illegal, not remapped
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module ofd_operand_decoder
  import ofd_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Decode request from fetch
  input  wire logic        dec_valid_in,
  input  wire logic [3:0]  dec_kind_in,
  input  wire logic        dec_byte_in,
  input  wire logic [22:0] dec_field_in,
  // Decoded operand to datapath
  output logic             dec_done_out,
  output logic             dec_illegal_out,
  output logic      [23:0] dec_value_out,
  output logic      [3:0]  dec_reg_a_out,
  output logic      [3:0]  dec_reg_b_out,
  output logic      [3:0]  dec_mod_out,
  output logic             dec_ofs_out,
  output logic             dec_none_out,
  output logic             dec_acc_b_out,
  output logic      [1:0]  dec_size_out,
  // Flag updates from datapath
  input  wire logic        core_we_in,
  input  wire logic        core_zsticky_in,
  input  wire logic [4:0]  core_flags_in,
  input  wire logic        dsp_we_in,
  input  wire logic [3:0]  dsp_flags_in,
  // Flags and interrupt
  output logic      [4:0]  core_flags_out,
  output logic      [3:0]  dsp_flags_out,
  output logic             irq_out
);

  // ========================================================
  // Reset release
  // ========================================================
  logic rst_s1_q;  // First stage, read only by second
  logic rst_n_q;   // Synchronised reset for the design

  // Async assert, clocked release
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ========================================================
  // Prefetch modifier table
  // ========================================================
  // Index 0..6 maps to +6 +4 +2 0 -6 -4 -2
  function automatic logic [3:0] pf_mod(
    input logic [3:0] k
  );
    case (k)
      4'h0:    pf_mod = 4'h6;
      4'h1:    pf_mod = 4'h4;
      4'h2:    pf_mod = 4'h2;
      4'h3:    pf_mod = 4'h0;
      4'h4:    pf_mod = 4'hA;
      4'h5:    pf_mod = 4'hC;
      default: pf_mod = 4'hE;
    endcase
  endfunction

  // ========================================================
  // Operand decode
  // ========================================================
  logic        dec_go;     // Request taken this cycle
  logic        ctrl_en_q;  // Software enable for decoding
  logic [23:0] val_d;      // Decoded value
  logic [3:0]  ra_d;       // First register
  logic [3:0]  rb_d;       // Second register
  logic [3:0]  md_d;       // Signed post-modify step
  logic        ofs_d;      // Offset by W12
  logic        none_d;     // Prefetch omitted
  logic        acc_d;      // Accumulator B chosen
  logic [1:0]  sz_d;       // Size code
  logic        ill_d;      // Encoding refused
  logic [3:0]  pfi;        // Prefetch index
  logic        pfhi;       // Second base register chosen

  assign dec_go = dec_valid_in & ctrl_en_q;
  assign pfi    = dec_field_in[3:0];
  assign pfhi   = (pfi >= OFD_PF_SPLIT);

  // Field decode by kind; results are cleared when illegal
  always_comb begin
    val_d  = '0;
    ra_d   = '0;
    rb_d   = '0;
    md_d   = '0;
    ofs_d  = 1'b0;
    none_d = 1'b0;
    acc_d  = 1'b0;
    sz_d   = '0;
    ill_d  = 1'b0;
    case (ofd_kind_type'(dec_kind_in))
      OFD_K_AWB: begin
        // Only two targets exist
        ra_d = OFD_W13; // RL1
        if (dec_field_in[1]) begin
          ill_d = 1'b1; // RL18
        end else if (dec_field_in[0]) begin
          md_d = OFD_AWB_STEP; // RL1
        end
      end
      OFD_K_BIT: begin
        // One-hot mask and index
        val_d = {8'h00, 16'h0001 << dec_field_in[3:0]}; // RL2
        ra_d  = dec_field_in[3:0]; // RL2
      end
      OFD_K_FILE: begin
        val_d = {11'h000, dec_field_in[OFD_FILE_W-1:0]}; // RL3
        ill_d = |dec_field_in[22:OFD_FILE_W]; // RL18
      end
      OFD_K_TEN_BIT_UNSIGNED_LITERAL: begin
        val_d = {14'h0000, dec_field_in[9:0]};
        // Byte mode caps the literal
        ill_d = dec_byte_in &&
                (dec_field_in[9:0] > OFD_BYTE_MAX); // RL4
      end
      OFD_K_PROGRAM_ADDRESS_LITERAL: begin
        val_d = {1'b0, dec_field_in};
        ill_d = dec_field_in[0]; // RL5
      end
      OFD_K_TEN_BIT_SIGNED_LITERAL: begin
        val_d = {{14{dec_field_in[9]}},
                 dec_field_in[9:0]}; // RL6
      end
      OFD_K_SLIT16: begin
        val_d = {{8{dec_field_in[15]}},
                 dec_field_in[15:0]}; // RL6
      end
      OFD_K_SLIT6: begin
        val_d = {{18{dec_field_in[5]}},
                 dec_field_in[5:0]}; // RL6
      end
      OFD_K_WDEF: begin
        ra_d = OFD_W0; // RL7
      end
      OFD_K_SQR: begin
        // Both operands the same register
        ra_d = OFD_W4 + {2'b00, dec_field_in[1:0]}; // RL8
        rb_d = OFD_W4 + {2'b00, dec_field_in[1:0]}; // RL8
      end
      OFD_K_MUL: begin
        // Six pairs, codes 6 and 7 refused
        case (dec_field_in[2:0])
          3'h0: begin ra_d = OFD_W4; rb_d = OFD_W5; end
          3'h1: begin ra_d = OFD_W4; rb_d = OFD_W6; end
          3'h2: begin ra_d = OFD_W4; rb_d = OFD_W7; end
          3'h3: begin ra_d = OFD_W5; rb_d = OFD_W6; end
          3'h4: begin ra_d = OFD_W5; rb_d = OFD_W7; end
          3'h5: begin ra_d = OFD_W6; rb_d = OFD_W7; end
          default: ill_d = 1'b1; // RL18
        endcase // RL9
      end
      OFD_K_XPF, OFD_K_YPF: begin
        // Destination register W4..W7
        rb_d = OFD_W4 + {2'b00, dec_field_in[5:4]}; // RL12
        ra_d = (dec_kind_in == OFD_K_XPF) ?
               OFD_W8 : OFD_W10; // RL10 RL11
        if (pfi == OFD_PF_NONE) begin
          none_d = 1'b1; // RL10 RL11
          ra_d   = '0;
          rb_d   = '0;
        end else if (pfi == OFD_PF_OFS) begin
          // Second base offset by W12
          ra_d  = ra_d + 4'h1;
          ofs_d = 1'b1; // RL10 RL11
        end else begin
          ra_d = ra_d + {3'b000, pfhi};
          md_d = pf_mod(pfhi ? pfi - OFD_PF_SPLIT : pfi);
        end
      end
      OFD_K_ACC: begin
        acc_d = dec_field_in[0]; // RL15
      end
      OFD_K_DEFAULT_FILE_WORKING_REG: begin
        ra_d = dec_field_in[3:0]; // RL16
      end
      OFD_K_SIZE: begin
        // 0 word, 1 byte, 2 double, 3 shadow
        sz_d = dec_field_in[1:0]; // RL17
      end
      default: ill_d = 1'b1; // RL18
    endcase
    if (ill_d) begin
      // Never remap to a valid operand
      val_d  = '0; // RL18
      ra_d   = '0;
      rb_d   = '0;
      md_d   = '0;
      ofs_d  = 1'b0;
      none_d = 1'b0;
      acc_d  = 1'b0;
      sz_d   = '0;
    end
  end

  // Output registers for the decoded operand
  always_ff @(posedge mclk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dec_done_out    <= 1'b0;
      dec_illegal_out <= 1'b0;
      dec_value_out   <= '0;
      dec_reg_a_out   <= '0;
      dec_reg_b_out   <= '0;
      dec_mod_out     <= '0;
      dec_ofs_out     <= 1'b0;
      dec_none_out    <= 1'b0;
      dec_acc_b_out   <= 1'b0;
      dec_size_out    <= '0;
    end else begin
      dec_done_out <= dec_go;
      if (dec_go) begin
        dec_illegal_out <= ill_d;
        dec_value_out   <= val_d;
        dec_reg_a_out   <= ra_d;
        dec_reg_b_out   <= rb_d;
        dec_mod_out     <= md_d;
        dec_ofs_out     <= ofs_d;
        dec_none_out    <= none_d;
        dec_acc_b_out   <= acc_d;
        dec_size_out    <= sz_d;
      end
    end
  end

  // ========================================================
  // Registers, flags and interrupt
  // ========================================================
  logic             bus_req;   // New access this cycle
  logic             bus_wr;    // Write takes effect
  logic [15:0]      wmask;     // Byte lane mask
  logic [15:0]      wdat;      // Masked write helper
  logic             ctrl_en_d;
  logic [4:0]       core_d;
  logic [3:0]       dsp_d;
  logic [OFD_I_W-1:0] ist_q;   // Sticky events
  logic [OFD_I_W-1:0] ist_d;
  logic [OFD_I_W-1:0] imask_q; // Event enables
  logic [OFD_I_W-1:0] imask_d;
  logic [OFD_I_W-1:0] ev;      // Events this cycle
  logic [31:0]      rdat_d;
  logic             ack_d;

  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // Writes land at the edge where the master sees ack, while the
  // request is still held, so a write never lands ahead of its answer
  assign bus_wr  = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in;
  assign wmask   = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wdat    = wb_dat_in[15:0] & wmask;

  // Events: illegal encoding, decode done, clip raised
  assign ev[OFD_I_ILL]  = dec_go & ill_d;
  assign ev[OFD_I_DONE] = dec_go;
  assign ev[OFD_I_SAT]  = dsp_we_in &
    (dsp_flags_in[OFD_D_SA] | dsp_flags_in[OFD_D_SB]);

  // Next state of control, flags and bus answer
  always_comb begin
    ctrl_en_d = ctrl_en_q;
    core_d    = core_flags_out;
    dsp_d     = dsp_flags_out;
    imask_d   = imask_q;
    ist_d     = ist_q;
    ack_d     = bus_req;
    rdat_d    = '0;
    // Software writes, byte lanes honoured
    if (bus_wr) begin
      case (wb_adr_in)
        OFD_A_CTRL: begin
          if (wb_sel_in[0]) begin
            ctrl_en_d = wb_dat_in[0];
          end
        end
        OFD_A_ISTAT: begin
          // Write one to clear
          ist_d = ist_q & ~wdat[OFD_I_W-1:0];
        end
        OFD_A_IMASK: begin
          imask_d = (imask_q & ~wmask[OFD_I_W-1:0]) |
                    wdat[OFD_I_W-1:0];
        end
        OFD_A_CORE: begin
          core_d = (core_flags_out & ~wmask[4:0]) |
                   wdat[4:0];
        end
        OFD_A_DSP: begin
          dsp_d = (dsp_flags_out & ~wmask[3:0]) |
                  wdat[3:0];
        end
        default: ;
      endcase
    end
    // Datapath updates take priority over software
    if (core_we_in) begin
      core_d = core_flags_in; // RL13
      if (core_zsticky_in) begin
        // Zero may clear but never set here
        core_d[OFD_F_Z] = core_flags_out[OFD_F_Z] &
                          core_flags_in[OFD_F_Z]; // RL13
      end
    end
    if (dsp_we_in) begin
      dsp_d = dsp_flags_in; // RL14
    end
    // Set wins over a clear in the same cycle
    ist_d = ist_d | ev;
    // Read data; unmapped reads return zero
    if (bus_req && !wb_we_in) begin
      case (wb_adr_in)
        OFD_A_CTRL:  rdat_d[0] = ctrl_en_q;
        OFD_A_ISTAT: rdat_d[OFD_I_W-1:0] = ist_q;
        OFD_A_IMASK: rdat_d[OFD_I_W-1:0] = imask_q;
        OFD_A_CORE:  rdat_d[4:0] = core_flags_out;
        OFD_A_DSP:   rdat_d[3:0] = dsp_flags_out;
        OFD_A_LAST:  rdat_d[23:0] = dec_value_out;
        default:     rdat_d = '0;
      endcase
    end
  end

  // Register the control group
  always_ff @(posedge mclk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_en_q      <= 1'b0;
      core_flags_out <= '0;
      dsp_flags_out  <= '0;
      ist_q          <= '0;
      imask_q        <= '0;
      wb_ack_out     <= 1'b0;
      wb_dat_out     <= '0;
      irq_out        <= 1'b0;
    end else begin
      ctrl_en_q      <= ctrl_en_d;
      core_flags_out <= core_d;
      dsp_flags_out  <= dsp_d;
      ist_q          <= ist_d;
      imask_q        <= imask_d;
      wb_ack_out     <= ack_d;
      wb_dat_out     <= rdat_d;
      // Level output from the next status and mask
      irq_out        <= |(ist_d & imask_d);
    end
  end

endmodule // ofd_operand_decoder

// ==== bench/ofd_assertions.sv ====
`timescale 1ns/1ps
// ==========================================================
// Port checks for the operand decoder
// ==========================================================
module ofd_assertions
  import ofd_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_ack_out,
  // Decode port
  input wire logic        dec_valid_in,
  input wire logic [3:0]  dec_kind_in,
  input wire logic        dec_byte_in,
  input wire logic [22:0] dec_field_in,
  input wire logic        dec_done_out,
  input wire logic        dec_illegal_out,
  input wire logic [23:0] dec_value_out,
  input wire logic [3:0]  dec_reg_a_out,
  input wire logic [3:0]  dec_mod_out,
  // Core flags
  input wire logic        core_we_in,
  input wire logic        core_zsticky_in,
  input wire logic [4:0]  core_flags_in,
  input wire logic [4:0]  core_flags_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // A result together with the kind that was asked for
  sequence s_done(logic [3:0] k);
    dec_done_out && $past(dec_kind_in) == k;
  endsequence

  // ==========================================================
  // Properties
  // ==========================================================
  property p_ack;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack late or long");

  property p_done;
    dec_done_out |-> $past(dec_valid_in);
  endproperty
  a_done: assert property (p_done) else $error("done without request");

  property p_awb;
    s_done(OFD_K_AWB) |-> dec_illegal_out == $past(dec_field_in[1]) &&
      (dec_illegal_out || dec_reg_a_out == OFD_W13 &&
       dec_mod_out == {2'h0, $past(dec_field_in[0]), 1'h0});
  endproperty
  a_awb: assert property (p_awb) else $error("write-back wrong");

  property p_bit;
    s_done(OFD_K_BIT) |-> dec_value_out == 24'h1 << $past(dec_field_in[3:0]);
  endproperty
  a_bit: assert property (p_bit) else $error("bit mask wrong");

  property p_file;
    s_done(OFD_K_FILE) |-> dec_illegal_out == |$past(dec_field_in[22:13]);
  endproperty
  a_file: assert property (p_file) else $error("file range wrong");

  property p_ten_bit_unsigned_literal;
    s_done(OFD_K_TEN_BIT_UNSIGNED_LITERAL) |-> dec_illegal_out ==
      ($past(dec_byte_in) && $past(dec_field_in[9:0]) > 10'h0FF);
  endproperty
  a_ten_bit_unsigned_literal: assert property (p_ten_bit_unsigned_literal) else $error("lit range wrong");

  property p_program_address_literal;
    s_done(OFD_K_PROGRAM_ADDRESS_LITERAL) |-> dec_illegal_out == $past(dec_field_in[0]);
  endproperty
  a_program_address_literal: assert property (p_program_address_literal) else $error("odd address");

  property p_wdef;
    s_done(OFD_K_WDEF) |-> dec_reg_a_out == OFD_W0 && !dec_illegal_out;
  endproperty
  a_wdef: assert property (p_wdef) else $error("default reg");

  property p_zsticky;
    core_we_in && core_zsticky_in && !core_flags_in[OFD_F_Z]
      |=> !core_flags_out[OFD_F_Z];
  endproperty
  a_zsticky: assert property (p_zsticky) else $error("zero set");
endmodule // ofd_assertions

// ==== bench/ofd_fetch_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Fetch stage stand-in: registers one request per cycle
// ==========================================================
module ofd_fetch_model (
  // Clock and request from the bench
  input  wire logic        mclk_in,
  input  wire logic        go_in,
  input  wire logic [3:0]  kind_in,
  input  wire logic        byte_in,
  input  wire logic [22:0] field_in,
  // Request towards the decoder
  output logic             valid_out = 1'h0,
  output logic      [3:0]  kind_out  = 4'h0,
  output logic             byte_out  = 1'h0,
  output logic      [22:0] field_out = 23'h0
);
  // Idle fields toggle so a stale value is never mistaken for data
  always @(posedge mclk_in) begin
    valid_out <= go_in;
    kind_out  <= go_in ? kind_in : ~kind_out;
    byte_out  <= go_in ? byte_in : ~byte_out;
    field_out <= go_in ? field_in : ~field_out;
  end
endmodule // ofd_fetch_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
// ==========================================================
// Operand decoder bench
// ==========================================================
module tb
  import ofd_pkg::*;
;
  typedef struct packed {
    logic [3:0]  k;   // Kind asked for
    logic        ill; // Expected illegal flag
    logic [23:0] key; // Expected fields of interest
  } ofd_tb_note_type;
  localparam logic [3:0] MODS [7] = '{4'h6, 4'h4, 4'h2, 4'h0,
                                      4'hA, 4'hC, 4'hE};
  logic mclk_in = 0, rst_n_in = 0, go = 0, gbyte = 0, en = 0;
  logic wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0, gkind = 4'h0, dsp_flags_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic [22:0] gfield = 23'h0, dec_field_in;
  logic [3:0] dec_kind_in, dec_reg_a_out, dec_reg_b_out, dec_mod_out;
  logic dec_valid_in, dec_byte_in, dec_done_out, dec_illegal_out, wb_ack_out;
  logic dec_ofs_out, dec_none_out, dec_acc_b_out, irq_out;
  logic core_we_in = 0, core_zsticky_in = 0, dsp_we_in = 0;
  logic [4:0] core_flags_in = 5'h0, core_flags_out;
  logic [3:0] dsp_flags_out;
  logic [1:0] dec_size_out;
  logic [23:0] dec_value_out;
  int num_errors = 0, compares = 0, seed = 35;
  ofd_tb_note_type notes[$];

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  ofd_fetch_model u_fetch (.mclk_in, .go_in(go), .kind_in(gkind),
    .byte_in(gbyte), .field_in(gfield), .valid_out(dec_valid_in),
    .kind_out(dec_kind_in), .byte_out(dec_byte_in),
    .field_out(dec_field_in));
  ofd_operand_decoder dut (.mclk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .dec_valid_in, .dec_kind_in, .dec_byte_in,
    .dec_field_in, .dec_done_out, .dec_illegal_out, .dec_value_out,
    .dec_reg_a_out, .dec_reg_b_out, .dec_mod_out, .dec_ofs_out,
    .dec_none_out, .dec_acc_b_out, .dec_size_out, .core_we_in,
    .core_zsticky_in, .core_flags_in, .dsp_we_in, .dsp_flags_in,
    .core_flags_out, .dsp_flags_out, .irq_out);

  task automatic fail(string s);
    num_errors++;
    $display("CHECK FAILED %0t %s", $time, s);
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Reference decode, kept apart from the design's own logic
  // ==========================================================
  function automatic ofd_tb_note_type model(logic [3:0] k, logic b,
                                           logic [22:0] f);
    ofd_tb_note_type n;
    logic [3:0] d, x;
    n = '{k, 1'h0, 24'h0};
    d = OFD_W4 + 4'(f[5:4]);
    x = (k == OFD_K_XPF) ? OFD_W8 : OFD_W10;
    case (k)
      OFD_K_AWB: if (f[1]) n.ill = 1;
        else n.key = {16'h0, OFD_W13, 2'h0, f[0], 1'h0};
      OFD_K_BIT: n.key = 24'h1 << f[3:0];
      OFD_K_FILE: if (|f[22:13]) n.ill = 1; else n.key = 24'(f);
      OFD_K_TEN_BIT_UNSIGNED_LITERAL: if (b && f > 255) n.ill = 1; else n.key = 24'(f);
      OFD_K_PROGRAM_ADDRESS_LITERAL: if (f[0]) n.ill = 1; else n.key = 24'(f);
      OFD_K_TEN_BIT_SIGNED_LITERAL: n.key = 24'(signed'(f[9:0]));
      OFD_K_SLIT16: n.key = 24'(signed'(f[15:0]));
      OFD_K_SLIT6: n.key = 24'(signed'(f[5:0]));
      OFD_K_WDEF: n.key = 24'h0;
      OFD_K_SQR: n.key = {16'h0, {2{OFD_W4 + 4'(f[1:0])}}};
      OFD_K_MUL: case (f[2:0])
        0: n.key = 24'h45; 1: n.key = 24'h46; 2: n.key = 24'h47;
        3: n.key = 24'h56; 4: n.key = 24'h57; 5: n.key = 24'h67;
        default: n.ill = 1;
      endcase
      OFD_K_ACC: n.key = 24'(f[0]);
      OFD_K_DEFAULT_FILE_WORKING_REG: n.key = 24'(f[3:0]);
      OFD_K_SIZE: n.key = 24'(f[1:0]);
      default: if (f[3:0] == 4'hF) n.key = 24'h1;
        else if (f[3:0] == 4'hE) n.key = {6'h0, x + 4'h1, d, 6'h2};
        else n.key = {6'h0, x + 4'(f[3:0] > 6), d,
                      MODS[f[3:0] % 7], 2'h0};
    endcase
    return n;
  endfunction

  function automatic logic [23:0] pick(logic [3:0] k);
    case (k)
      OFD_K_AWB: return {16'h0, dec_reg_a_out, dec_mod_out};
      OFD_K_WDEF, OFD_K_SQR, OFD_K_MUL:
        return {16'h0, dec_reg_a_out, dec_reg_b_out};
      OFD_K_XPF, OFD_K_YPF:
        return {6'h0, dec_reg_a_out, dec_reg_b_out, dec_mod_out,
                dec_ofs_out, dec_none_out};
      OFD_K_ACC: return 24'(dec_acc_b_out);
      OFD_K_DEFAULT_FILE_WORKING_REG: return 24'(dec_reg_a_out);
      OFD_K_SIZE: return 24'(dec_size_out);
      default: return dec_value_out;
    endcase
  endfunction

  // Result watcher: oldest note against each done pulse
  always @(posedge mclk_in) begin
    ofd_tb_note_type n;
    if (dec_done_out === 1'h1) begin
      if (notes.size() == 0) fail("done with nothing asked");
      else begin
        n = notes.pop_front();
        compares++;
        if (dec_illegal_out !== n.ill || pick(n.k) !== n.key)
          fail("decode result");
      end
    end
  end

  // ==========================================================
  // Drivers
  // ==========================================================
  task automatic issue(logic [3:0] k, logic b, logic [22:0] f);
    @(posedge mclk_in);
    go <= 1;
    gkind <= k;
    gbyte <= b;
    gfield <= f;
    if (en) notes.push_back(model(k, b, f));
  endtask

  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    @(posedge mclk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in} <= {2'h3, w, a};
    wb_dat_in <= d;
    wb_sel_in <= 4'h3;
    t = 0;
    do begin
      @(posedge mclk_in);
      t++;
    end while (wb_ack_out !== 1'h1 && t < 50);
    if (t >= 50) begin
      fail("no bus ack");
      tally_and_finish();
    end
    q = wb_dat_out;
    {wb_cyc_in, wb_stb_in, wb_sel_in} <= 6'h0;
  endtask

  task automatic rd_chk(logic [7:0] a, logic [31:0] e);
    wb(0, a, 32'h0);
    compares++;
    if (q !== e) fail("register read");
  endtask

  task automatic out_chk(logic [8:0] got, logic [8:0] e);
    compares++;
    if (got !== e) fail("output level");
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    // Field width per kind, in the order of the kind enum
    int wid [16] = '{2, 4, 14, 10, 23, 10, 16, 6,
                     4, 2, 3, 6, 6, 1, 4, 2};
    logic [4:0] fin [4] = '{5'h1F, 5'h10, 5'h0F, 5'h10};
    logic [4:0] fex [4] = '{5'h1F, 5'h10, 5'h0F, 5'h00};
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1;
    repeat (3) @(posedge mclk_in);
    issue(OFD_K_BIT, 0, 23'h5); // Refused while disabled
    @(posedge mclk_in) go <= 0;
    rd_chk(OFD_A_CTRL, 32'h0);
    wb(1, 8'h20, 32'hFFFF);
    rd_chk(8'h20, 32'h0);
    wb(1, OFD_A_CTRL, 32'h1);
    en = 1;
    issue(OFD_K_TEN_BIT_UNSIGNED_LITERAL, 1, 23'hFF);
    issue(OFD_K_TEN_BIT_UNSIGNED_LITERAL, 1, 23'h100);
    issue(OFD_K_TEN_BIT_UNSIGNED_LITERAL, 0, 23'h3FF);
    for (int r = 0; r < 12; r++)
      for (int i = 0; i < 16; i++)
        issue(4'(i), 1'($random(seed)),
              23'($random(seed)) & 23'((1 << wid[i]) - 1));
    @(posedge mclk_in) go <= 0;
    repeat (4) @(posedge mclk_in);
    rd_chk(OFD_A_ISTAT, 32'h3);
    out_chk(9'(irq_out), 9'h0);
    wb(1, OFD_A_IMASK, 32'h2);
    repeat (2) @(posedge mclk_in);
    out_chk(9'(irq_out), 9'h1);
    wb(1, OFD_A_ISTAT, 32'h2);
    repeat (2) @(posedge mclk_in);
    out_chk(9'(irq_out), 9'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      {core_we_in, core_zsticky_in, core_flags_in} <= {1'h1, i != 0, fin[i]};
      @(posedge mclk_in) core_we_in <= 0;
      @(posedge mclk_in) out_chk(9'(core_flags_out), 9'(fex[i]));
    end
    @(posedge mclk_in) {dsp_we_in, dsp_flags_in} <= 5'h18;
    @(posedge mclk_in) dsp_we_in <= 0;
    @(posedge mclk_in) out_chk(9'(dsp_flags_out), 9'h8);
    rd_chk(OFD_A_ISTAT, 32'h5);
    wb(1, OFD_A_IMASK, 32'h4);
    repeat (2) @(posedge mclk_in);
    out_chk(9'(irq_out), 9'h1);
    // Every request asked for must have come back
    compares++;
    if (notes.size() != 0) fail("results missing");
    tally_and_finish();
  end

  // Watchdog well past the expected run length
  initial begin
    #20000;
    fail("timeout");
    tally_and_finish();
  end
endmodule // tb

bind ofd_operand_decoder ofd_assertions u_chk (.mclk_in, .rst_n_in,
  .wb_cyc_in, .wb_stb_in, .wb_ack_out, .dec_valid_in, .dec_kind_in,
  .dec_byte_in, .dec_field_in, .dec_done_out, .dec_illegal_out,
  .dec_value_out, .dec_reg_a_out, .dec_mod_out, .core_we_in,
  .core_zsticky_in, .core_flags_in, .core_flags_out);
